// ---- rtl/lsdc_defs.svh ----
// register offsets, field positions and timing counts for the laser drive safety block
`ifndef LSDC_DEFS_SVH
`define LSDC_DEFS_SVH
`define LSDC_ADDR_RANGE_MODE 7'h1A
`define LSDC_ADDR_CURRENT 7'h1C
`define LSDC_ADDR_CURRENT_INV 7'h1D
`define LSDC_ADDR_RANGE_MODE_INV 7'h1F
`define LSDC_BIT_RANGE 7
`define LSDC_CAL_HI 3
`define LSDC_CAL_LO 1
`define LSDC_RST_RANGE_MODE 8'h00
`define LSDC_RST_RANGE_MODE_INV 8'hFF
`define LSDC_RST_CURRENT 8'h00
`define LSDC_RST_CURRENT_INV 8'hFF
`define LSDC_CAL_ON 3'h7
`define LSDC_PULSE_PERIOD_US 100
`define LSDC_PULSE_ON_US 10
`define LSDC_TEST_PERIOD_US 1000
`define LSDC_TEST_SETTLE_US 2
`define LSDC_DET_BLANK_CYC 3
`define LSDC_CLK_MHZ 10
`endif

// ---- rtl/lsdc_pkg.sv ----
// types shared by the laser drive safety block
package lsdc_pkg;
  typedef enum logic [1:0] {
    LSDC_ST_RUN,
    LSDC_ST_TEST_SETTLE,
    LSDC_ST_TEST_CHECK,
    LSDC_ST_FAULT
  } lsdc_state_t;
endpackage

// ---- rtl/lsdc_wr_if.sv ----
// register write strobe carried from the serial receiver to the register file
`timescale 1ns/10ps
interface lsdc_wr_if;
  logic wr_stb;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  modport src (output wr_stb, output wr_addr, output wr_data);
  modport dst (input wr_stb, input wr_addr, input wr_data);
endinterface

// ---- rtl/lsdc_spi_rx.sv ----
// serial write receiver: address byte with msb set, then data byte
`timescale 1ns/10ps
module lsdc_spi_rx
  import lsdc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic mosi,
  lsdc_wr_if.src wr
);
  logic [2:0] ncs_sync_r, ncs_sync_nxt;
  logic [2:0] sclk_sync_r, sclk_sync_nxt;
  logic [1:0] mosi_sync_r, mosi_sync_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic is_wr_r, is_wr_nxt;
  logic stb_r, stb_nxt;
  logic [7:0] data_r, data_nxt;
  logic rise;
  logic [7:0] byte_in;

  // ****************************************
  // sampling on rising serial clock
  // ****************************************
  always_comb begin
    ncs_sync_nxt = {ncs_sync_r[1:0], ncs_n};
    sclk_sync_nxt = {sclk_sync_r[1:0], sclk};
    mosi_sync_nxt = {mosi_sync_r[0], mosi};
    rise = sclk_sync_r[1] && !sclk_sync_r[2];
    byte_in = {shift_r[6:0], mosi_sync_r[1]};
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    addr_nxt = addr_r;
    is_wr_nxt = is_wr_r;
    data_nxt = data_r;
    stb_nxt = 1'b0;
    // frame end aborts any partial transaction
    if (ncs_sync_r[1]) begin
      cnt_nxt = 4'h0;
    end else if (rise) begin
      shift_nxt = byte_in;
      if (cnt_r == 4'h7) begin
        addr_nxt = byte_in[6:0];
        is_wr_nxt = byte_in[7];
        cnt_nxt = 4'h8;
      end else if (cnt_r == 4'hF) begin
        data_nxt = byte_in;
        stb_nxt = is_wr_r;
        cnt_nxt = 4'h0;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ncs_sync_r <= 3'h7;
      sclk_sync_r <= 3'h7;
      mosi_sync_r <= 2'h0;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      addr_r <= 7'h00;
      is_wr_r <= 1'b0;
      data_r <= 8'h00;
      stb_r <= 1'b0;
    end else if (clk_en) begin
      ncs_sync_r <= ncs_sync_nxt;
      sclk_sync_r <= sclk_sync_nxt;
      mosi_sync_r <= mosi_sync_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      addr_r <= addr_nxt;
      is_wr_r <= is_wr_nxt;
      data_r <= data_nxt;
      stb_r <= stb_nxt;
    end
  end

  assign wr.wr_stb = stb_r;
  assign wr.wr_addr = addr_r;
  assign wr.wr_data = data_r;
endmodule

// ---- rtl/lsdc_top.sv ----
// laser drive control: range, calibration mode, current setting and single fault shutdown
`timescale 1ns/10ps
`include "lsdc_defs.svh"

// Operation
// - pulsed drive normally, continuous in calibration
// - range bit seven selects high current
// - calibration bits give full duty cycle
// - current setting held with complement copy
// - switch enable low in normal operation
// - cathode fault raises switch enable
// - ground fault turns drive source off
// - detector self tested periodically, once every TEST_PERIOD_CYC run cycles
// - failed self test is a fault
// - writes are address then data bytes
module lsdc_top
  import lsdc_pkg::*;
#(
  parameter int TEST_PERIOD_CYC = `LSDC_TEST_PERIOD_US * `LSDC_CLK_MHZ
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cathode_gnd_det,
  output logic laser_switch_enable_n,
  output logic laser_drive_on,
  output logic laser_range_high,
  output logic [7:0] laser_drive_level,
  output logic cathode_test_pull,
  output logic laser_fault
);
  localparam int PULSE_PERIOD_CYC = `LSDC_PULSE_PERIOD_US * `LSDC_CLK_MHZ;
  localparam int PULSE_ON_CYC = `LSDC_PULSE_ON_US * `LSDC_CLK_MHZ;
  localparam int SETTLE_CYC = `LSDC_TEST_SETTLE_US * `LSDC_CLK_MHZ;
  // detector output decays slowly after the test pull is released
  localparam int BLANK_CYC = `LSDC_DET_BLANK_CYC;

  lsdc_wr_if wr_bus();

  lsdc_spi_rx u_rx (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .ncs_n(ncs_n),
    .sclk(sclk),
    .mosi(mosi),
    .wr(wr_bus)
  );

  // true when a register and its copy are exact complements
  function automatic logic pair_ok(input logic [7:0] a, input logic [7:0] b);
    pair_ok = (a == ~b);
  endfunction

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] range_mode_r, range_mode_nxt;
  logic [7:0] range_mode_inv_r, range_mode_inv_nxt;
  logic [7:0] current_r, current_nxt;
  logic [7:0] current_inv_r, current_inv_nxt;

  always_comb begin
    range_mode_nxt = range_mode_r;
    range_mode_inv_nxt = range_mode_inv_r;
    current_nxt = current_r;
    current_inv_nxt = current_inv_r;
    if (wr_bus.wr_stb) begin
      unique case (wr_bus.wr_addr)
        `LSDC_ADDR_RANGE_MODE: range_mode_nxt = wr_bus.wr_data;
        `LSDC_ADDR_RANGE_MODE_INV: range_mode_inv_nxt = wr_bus.wr_data;
        `LSDC_ADDR_CURRENT: current_nxt = wr_bus.wr_data;
        `LSDC_ADDR_CURRENT_INV: current_inv_nxt = wr_bus.wr_data;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      range_mode_r <= `LSDC_RST_RANGE_MODE;
      range_mode_inv_r <= `LSDC_RST_RANGE_MODE_INV;
      current_r <= `LSDC_RST_CURRENT;
      current_inv_r <= `LSDC_RST_CURRENT_INV;
    end else if (clk_en) begin
      range_mode_r <= range_mode_nxt;
      range_mode_inv_r <= range_mode_inv_nxt;
      current_r <= current_nxt;
      current_inv_r <= current_inv_nxt;
    end
  end

  // ****************************************
  // validated settings
  // ****************************************
  logic ctrl_valid, cal_mode, range_bit;
  logic range_pair_ok, current_pair_ok;
  assign range_pair_ok = pair_ok(range_mode_r, range_mode_inv_r);
  assign current_pair_ok = pair_ok(current_r, current_inv_r);
  assign ctrl_valid = range_pair_ok && current_pair_ok;
  assign cal_mode = (range_mode_r[`LSDC_CAL_HI:`LSDC_CAL_LO] == `LSDC_CAL_ON);
  assign range_bit = range_mode_r[`LSDC_BIT_RANGE];

  // ****************************************
  // pulse timer and fault supervisor
  // ****************************************
  logic [1:0] det_sync_r, det_sync_nxt;
  logic [15:0] pulse_cnt_r, pulse_cnt_nxt;
  logic [15:0] test_cnt_r, test_cnt_nxt;
  lsdc_state_t state_r, state_nxt;
  logic drive_r, drive_nxt;
  logic range_out_r, range_out_nxt;
  logic [7:0] level_r, level_nxt;
  logic sw_n_r, sw_n_nxt;
  logic pull_r, pull_nxt;
  logic det;
  logic det_live;

  assign det = det_sync_r[1];
  // ignore the detector while it still echoes the test pull
  assign det_live = det && (test_cnt_r >= 16'(BLANK_CYC));

  always_comb begin
    det_sync_nxt = {det_sync_r[0], cathode_gnd_det};
    state_nxt = state_r;
    test_cnt_nxt = test_cnt_r;
    // pulse phase runs free so mode changes keep the duty
    pulse_cnt_nxt = (pulse_cnt_r == 16'(PULSE_PERIOD_CYC - 1)) ? 16'h0000 : pulse_cnt_r + 16'h0001;
    pull_nxt = 1'b0;
    unique case (state_r)
      LSDC_ST_RUN: begin
        if (det_live) begin
          state_nxt = LSDC_ST_FAULT;
        end else if (test_cnt_r == 16'(TEST_PERIOD_CYC - 1)) begin
          test_cnt_nxt = 16'h0000;
          state_nxt = LSDC_ST_TEST_SETTLE;
          pull_nxt = 1'b1;
        end else begin
          test_cnt_nxt = test_cnt_r + 16'h0001;
        end
      end
      LSDC_ST_TEST_SETTLE: begin
        pull_nxt = 1'b1;
        if (test_cnt_r == 16'(SETTLE_CYC - 1)) begin
          test_cnt_nxt = 16'h0000;
          state_nxt = LSDC_ST_TEST_CHECK;
        end else begin
          test_cnt_nxt = test_cnt_r + 16'h0001;
        end
      end
      LSDC_ST_TEST_CHECK: begin
        state_nxt = det ? LSDC_ST_RUN : LSDC_ST_FAULT;
      end
      LSDC_ST_FAULT: begin
        // only sys_rst leaves this state
        state_nxt = LSDC_ST_FAULT;
      end
    endcase
    drive_nxt = (state_nxt == LSDC_ST_RUN) && ctrl_valid &&
                (cal_mode || (pulse_cnt_nxt < 16'(PULSE_ON_CYC)));
    range_out_nxt = ctrl_valid ? range_bit : range_out_r;
    // current level from validated pair
    // a broken pair keeps the last good setting
    level_nxt = ctrl_valid ? current_r : level_r;
    sw_n_nxt = (state_nxt != LSDC_ST_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      det_sync_r <= 2'h0;
      pulse_cnt_r <= 16'h0000;
      test_cnt_r <= 16'h0000;
      state_r <= LSDC_ST_RUN;
      drive_r <= 1'b0;
      range_out_r <= 1'b0;
      level_r <= `LSDC_RST_CURRENT;
      sw_n_r <= 1'b0;
      pull_r <= 1'b0;
    end else if (clk_en) begin
      det_sync_r <= det_sync_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      test_cnt_r <= test_cnt_nxt;
      state_r <= state_nxt;
      drive_r <= drive_nxt;
      range_out_r <= range_out_nxt;
      level_r <= level_nxt;
      sw_n_r <= sw_n_nxt;
      pull_r <= pull_nxt;
    end
  end

  // ****************************************
  // pin and driver outputs
  // ****************************************
  assign laser_switch_enable_n = sw_n_r;
  assign laser_drive_on = drive_r;
  assign laser_range_high = range_out_r;
  assign laser_drive_level = level_r;
  assign cathode_test_pull = pull_r;
  assign laser_fault = (state_r == LSDC_ST_FAULT);
endmodule

// ---- test/lsdc_top_assertions.sv ----
// concurrent checks on the laser drive safety top level
`timescale 1ns/10ps
module lsdc_top_assertions #(
  parameter int TEST_PERIOD_CYC = 10000
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic cathode_gnd_det,
  input wire logic laser_switch_enable_n,
  input wire logic laser_drive_on,
  input wire logic laser_range_high,
  input wire logic [7:0] laser_drive_level,
  input wire logic cathode_test_pull,
  input wire logic laser_fault
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  int run_cnt_r;
  // run cycles since the last self test
  always_ff @(posedge core_clk) begin
    if (sys_rst || cathode_test_pull || laser_fault) begin
      run_cnt_r <= 0;
    end else if (clk_en) begin
      run_cnt_r <= run_cnt_r + 1;
    end
  end
  sequence s_det_run;
    (cathode_gnd_det && !cathode_test_pull && clk_en)[*3];
  endsequence
  sequence s_test_start;
    $rose(cathode_test_pull);
  endsequence
  a_reset_state: assert property ($past(sys_rst) |-> !laser_switch_enable_n && !laser_drive_on
    && !laser_range_high && laser_drive_level == 8'h00 && !cathode_test_pull && !laser_fault)
    else $error("outputs not at reset values");
  a_fault_cuts_drive: assert property (laser_fault && $past(laser_fault) |->
    laser_switch_enable_n && !laser_drive_on) else $error("fault leaves laser supplied");
  a_fault_latched: assert property (laser_fault && clk_en |=> laser_fault)
    else $error("fault cleared without reset");
  a_det_trips_fault: assert property (s_det_run |-> ##[0:4] (laser_fault || cathode_test_pull))
    else $error("ground path not flagged");
  a_test_cuts_supply: assert property (cathode_test_pull && $past(cathode_test_pull) |->
    laser_switch_enable_n && !laser_drive_on) else $error("self test with laser on");
  a_test_pull_len: assert property (s_test_start |-> cathode_test_pull[*8])
    else $error("self test pull too short");
  a_test_fail_trip: assert property ($fell(cathode_test_pull) && !$past(cathode_gnd_det)
    && !$past(cathode_gnd_det, 4) |-> ##[0:3] laser_fault) else $error("failed self test ignored");
  a_normal_sw_low: assert property ((!laser_fault && !cathode_test_pull)[*2] |-> !laser_switch_enable_n)
    else $error("switch enable high in normal run");
  a_test_periodic: assert property (run_cnt_r <= TEST_PERIOD_CYC + 4)
    else $error("self test overdue");
endmodule
bind lsdc_top lsdc_top_assertions #(.TEST_PERIOD_CYC(TEST_PERIOD_CYC)) lsdc_top_assertions_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .cathode_gnd_det(cathode_gnd_det),
  .laser_switch_enable_n(laser_switch_enable_n), .laser_drive_on(laser_drive_on),
  .laser_range_high(laser_range_high), .laser_drive_level(laser_drive_level),
  .cathode_test_pull(cathode_test_pull), .laser_fault(laser_fault));

// ---- test/lsdc_host_model.sv ----
// serial host model writing laser configuration registers
`timescale 1ns/10ps
module lsdc_host_model (
  input wire logic core_clk,
  output logic ncs_n,
  output logic sclk,
  output logic mosi
);
  initial begin
    ncs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {a, d};
    ncs_n = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = f[i];
      repeat (4) @(negedge core_clk);
      sclk = 1'b1;
      repeat (4) @(negedge core_clk);
    end
    repeat (8) @(negedge core_clk);
    ncs_n = 1'b1;
    mosi = ~mosi;
    repeat (8) @(negedge core_clk);
  endtask
endmodule

// ---- test/lsdc_top_tb.sv ----
// self-checking bench for the laser drive safety top level
`timescale 1ns/10ps
module lsdc_top_tb;
  localparam int TP = 2000;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic sg = 1'b0;
  logic sv = 1'b0;
  logic ncs_n, sclk, mosi, det, sw_n, drv, rng, pull, flt;
  logic [7:0] lvl;
  logic [7:0] el = 8'h00;
  logic er = 1'b0;
  logic [15:0] lfsr = 16'hA7EB;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int m[int];
  // healthy detector answers the test pull; shorts override it
  assign det = sg | (pull & ~sv);
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  lsdc_top #(.TEST_PERIOD_CYC(TP)) lsdc_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi), .cathode_gnd_det(det), .laser_switch_enable_n(sw_n),
    .laser_drive_on(drv), .laser_range_high(rng), .laser_drive_level(lvl), .cathode_test_pull(pull),
    .laser_fault(flt));
  lsdc_host_model lsdc_host_model_inst (.core_clk(core_clk), .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic rst();
    sys_rst = 1'b1;
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
    m[26] = 0;
    m[31] = 255;
    m[28] = 0;
    m[29] = 255;
    el = 8'h00;
    er = 1'b0;
  endtask
  // write, then let the model apply a complementary pair
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    lsdc_host_model_inst.wr(a, d);
    if (a[7]) m[a[6:0]] = d;
    if ((m[26] ^ m[31]) == 255 && (m[28] ^ m[29]) == 255) begin
      el = 8'(m[28]);
      er = 1'(m[26] >> 7);
    end
    chk("level", lvl, el);
    chk("range", rng, er);
  endtask
  task automatic duty(output int on, output int run);
    logic [2:0] ph;
    on = 0;
    run = 0;
    ph = 3'h7;
    repeat (1000) begin
      @(negedge core_clk);
      ph = {ph[1:0], pull | sw_n};
      run += (ph == 3'h0);
      on += (ph == 3'h0 && drv === 1'b1);
    end
  endtask
  initial begin
    int on, run;
    rst();
    chk("switch_n", sw_n, 0);
    duty(on, run);
    chk("pulsed", on > 0 && on <= 110, 1);
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      put(8'h9C, lfsr[7:0]);
      duty(on, run);
      if ((m[28] ^ m[29]) != 255) chk("unpaired_drive", on, 0);
      put(8'h9D, ~lfsr[7:0]);
    end
    put(8'h1C, 8'h5A);
    put(8'h9B, 8'h5A);
    put(8'h9A, 8'h80);
    put(8'h9F, 8'h7F);
    put(8'h9A, 8'h0E);
    put(8'h9F, 8'hF1);
    duty(on, run);
    chk("continuous", on, run);
    for (int s = 1; s < 4; s++) begin
      put(8'h9C, 8'(s * 37));
      put(8'h9D, ~8'(s * 37));
    end
    put(8'h9C, 8'h00);
    put(8'h9D, 8'hFF);
    put(8'h9A, 8'h8E);
    put(8'h9F, 8'h71);
    duty(on, run);
    chk("continuous_high", on == run && run > 0, 1);
    clk_en = 1'b0;
    lsdc_host_model_inst.wr(8'h9C, 8'h11);
    lsdc_host_model_inst.wr(8'h9D, 8'hEE);
    clk_en = 1'b1;
    chk("frozen_level", lvl, el);
    sg = 1'b1;
    repeat (40) begin
      @(negedge core_clk);
      if (flt === 1'b1) break;
    end
    chk("gnd_fault", {flt, sw_n, drv}, 3'h6);
    sg = 1'b0;
    repeat (50) @(negedge core_clk);
    chk("latched", flt, 1);
    rst();
    chk("cleared", {flt, sw_n, lvl}, 0);
    put(8'h9A, 8'h8E);
    put(8'h9F, 8'h71);
    put(8'h9C, 8'h2B);
    put(8'h9D, 8'hD4);
    duty(on, run);
    chk("reload_power", on == run && run > 0, 1);
    repeat (TP + 100) begin
      @(negedge core_clk);
      if (pull === 1'b1) break;
    end
    chk("self_test", {pull, sw_n, drv}, 3'h6);
    sv = 1'b1;
    repeat (TP + 100) begin
      @(negedge core_clk);
      if (flt === 1'b1) break;
    end
    chk("test_fail", {flt, sw_n, drv}, 3'h6);
    sv = 1'b0;
    rst();
    chk("after_reset", flt, 0);
    print_verdict();
  end
endmodule
